// ==== core/cpwm_timer.sv ====
// complementary pwm timer with buffered general registers
// Notes on behaviour
// - complementary mode makes pins pwm, counters up/down
// - three pairs of non-overlapping normal/inverse outputs
// - toggle output flips once per pwm cycle
// - down at counter0 cycle match, up at underflow
// - turns set compare flag; underflow sets flag
// - complementary overflow flag only for divide four or eight
// - buffers copy at top turn and underflow
// - zero duty value full, at or above cycle none
// - c buffers a, d buffers b
// - output compare match copies buffer in
// - capture loads counter, old value to buffer
// - reset-sync pwm copies buffers at match a0
`timescale 1ns/1ps
module cpwm_timer (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // mode control
  input  wire logic [1:0]  mode,
  input  wire logic        run,
  input  wire logic        buffer_en,
  input  wire logic        prescale_sel_bit2,
  input  wire logic        prescale_sel_bit1,
  input  wire logic        prescale_sel_bit0,
  // counter and register writes
  input  wire logic        cnt0_wr,
  input  wire logic        cnt1_wr,
  input  wire logic [15:0] cnt_wdata,
  input  wire logic [3:0]  gr0_wr,
  input  wire logic [3:0]  gr1_wr,
  input  wire logic [15:0] gr_wdata,
  // capture strobes for channel 0 general register a and b
  input  wire logic        capture_a,
  input  wire logic        capture_b,
  // flag clear strobes
  input  wire logic        clr_cmpa,
  input  wire logic        clr_udf,
  input  wire logic        clr_ovf,
  // state readback
  output logic [15:0]      counter_ch0,
  output logic [15:0]      counter_ch1,
  output logic [15:0]      cycle_compare_ch0,
  output logic [15:0]      duty_compare_pair1,
  output logic [15:0]      duty_compare_pair2,
  output logic [15:0]      duty_compare_pair3,
  output logic [15:0]      general_reg_c0,
  output logic [15:0]      general_reg_d0,
  output logic [15:0]      general_reg_c1,
  output logic [15:0]      general_reg_d1,
  output logic             counting_down,
  // flags
  output logic             compare_a_match_flag,
  output logic             underflow_flag,
  output logic             overflow_flag,
  // pwm pins
  output logic             pwm1_normal_out,
  output logic             pwm1_inverse_out,
  output logic             cycle_toggle_out,
  output logic             pwm2_normal_out,
  output logic             pwm2_inverse_out,
  output logic             pwm3_normal_out,
  output logic             pwm3_inverse_out
);
  // register state: index 0..3 = a,b,c,d per channel
  typedef struct packed {
    logic [1:0][3:0][15:0] gr;     // general registers per channel
    logic [15:0]           c0;     // counter channel 0
    logic [15:0]           c1;     // counter channel 1
    logic                  down;   // counting direction
    logic                  tog;    // cycle toggle
    logic                  fcmp;   // compare a match flag
    logic                  fudf;   // underflow flag
    logic                  fovf;   // overflow flag
  } cpwm_state_t;
  cpwm_state_t st_r;
  cpwm_state_t st_nxt;
  logic [2:0]  psel;      // prescale select
  logic        tick;      // count enable
  logic        comp_mode; // complementary mode active
  logic        top_hit;   // counter0 equals cycle while counting up
  logic        udf_hit;   // counter1 about to go below zero
  logic        wrap0;     // watched counter rolls from all ones
  logic        rs_match;  // reset-sync cycle match
  logic        oc_match_a;// output compare match a on channel 0
  logic        oc_match_b;// output compare match b on channel 0
  logic        cnt_div;   // a divided clock is selected
  logic        ovf_allow; // divide by four or eight
  assign psel = {prescale_sel_bit2, prescale_sel_bit1, prescale_sel_bit0};
  assign comp_mode = (cpwm_pkg::cpwm_mode_t'(mode) ==
                      cpwm_pkg::CPWM_MODE_COMP);
  assign cnt_div   = (psel != cpwm_pkg::PSC_DIV1);
  assign ovf_allow = (psel == cpwm_pkg::PSC_DIV4) ||
                     (psel == cpwm_pkg::PSC_DIV8);
  // prescaler
  cpwm_prescale u_ps (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (run),
    .sel   (psel),
    .tick  (tick)
  );
  // turn and match events, all qualified by the count enable
  always_comb begin
    top_hit    = comp_mode && tick && !st_r.down &&
                 (st_r.c0 == st_r.gr[0][0]);
    udf_hit    = comp_mode && tick && st_r.down &&
                 (st_r.c1 == cpwm_pkg::CNT_ZERO);
    // complementary mode: only counter 1 passes all ones, after undershoot
    wrap0      = tick && !st_r.down &&
                 ((comp_mode ? st_r.c1 : st_r.c0) == cpwm_pkg::CNT_MAX);
    rs_match   = (cpwm_pkg::cpwm_mode_t'(mode) ==
                  cpwm_pkg::CPWM_MODE_RSYN) && tick &&
                 (st_r.c0 == st_r.gr[0][0]);
    oc_match_a = (cpwm_pkg::cpwm_mode_t'(mode) ==
                  cpwm_pkg::CPWM_MODE_OCIC) && tick &&
                 (st_r.c0 == st_r.gr[0][0]);
    oc_match_b = (cpwm_pkg::cpwm_mode_t'(mode) ==
                  cpwm_pkg::CPWM_MODE_OCIC) && tick &&
                 (st_r.c0 == st_r.gr[0][1]);
  end
  // next state of counters, registers and flags
  always_comb begin
    st_nxt = st_r;
    // software writes to general registers
    for (int ch = 0; ch < 2; ch++) begin
      for (int i = 0; i < 4; i++) begin
        if ((ch == 0 ? gr0_wr[i] : gr1_wr[i])) begin
          st_nxt.gr[ch][i] = gr_wdata;
        end
      end
    end
    // counting
    if (!comp_mode) begin
      st_nxt.down = 1'b0;
      if (rs_match) begin
        st_nxt.c0  = cpwm_pkg::CNT_ZERO; // reset-sync clear
        st_nxt.tog = !st_r.tog;
      end else if (tick) begin
        st_nxt.c0 = 16'(st_r.c0 + cpwm_pkg::CNT_ONE);
      end
      if (tick) begin
        st_nxt.c1 = 16'(st_r.c1 + cpwm_pkg::CNT_ONE);
      end
    end else if (top_hit) begin
      // up-to-down turn: overshoot then count down
      st_nxt.down = 1'b1;
      st_nxt.tog  = !st_r.tog; // once per cycle
      st_nxt.c0   = 16'(st_r.c0 + cpwm_pkg::CNT_ONE);
      st_nxt.c1   = 16'(st_r.c1 + cpwm_pkg::CNT_ONE);
    end else if (udf_hit) begin
      // underflow turn: undershoot then count up
      st_nxt.down = 1'b0;
      st_nxt.c0   = 16'(st_r.c0 - cpwm_pkg::CNT_ONE);
      st_nxt.c1   = 16'(st_r.c1 - cpwm_pkg::CNT_ONE);
    end else if (tick) begin
      // both counters step together
      if (st_r.down) begin
        st_nxt.c0 = 16'(st_r.c0 - cpwm_pkg::CNT_ONE);
        st_nxt.c1 = 16'(st_r.c1 - cpwm_pkg::CNT_ONE);
      end else begin
        st_nxt.c0 = 16'(st_r.c0 + cpwm_pkg::CNT_ONE);
        st_nxt.c1 = 16'(st_r.c1 + cpwm_pkg::CNT_ONE);
      end
    end
    // software counter writes take priority over counting
    if (cnt0_wr) begin
      st_nxt.c0 = cnt_wdata;
    end
    if (cnt1_wr) begin
      st_nxt.c1 = cnt_wdata;
    end
    // buffer transfers, c into a and d into b
    if (buffer_en) begin
      if (top_hit || udf_hit) begin
        // complementary turns refresh all duty registers
        st_nxt.gr[0][1] = st_r.gr[0][3];
        st_nxt.gr[1][0] = st_r.gr[1][2];
        st_nxt.gr[1][1] = st_r.gr[1][3];
      end
      if (rs_match) begin
        // reset-sync transfer on channel 0 match a
        st_nxt.gr[0][1] = st_r.gr[0][3];
        st_nxt.gr[1][0] = st_r.gr[1][2];
        st_nxt.gr[1][1] = st_r.gr[1][3];
      end
      if (oc_match_a) begin
        st_nxt.gr[0][0] = st_r.gr[0][2];
      end
      if (oc_match_b) begin
        st_nxt.gr[0][1] = st_r.gr[0][3];
      end
    end
    // input capture beats software writes
    if (cpwm_pkg::cpwm_mode_t'(mode) == cpwm_pkg::CPWM_MODE_OCIC) begin
      if (capture_a) begin
        st_nxt.gr[0][0] = st_r.c0;
        if (buffer_en) begin
          st_nxt.gr[0][2] = st_r.gr[0][0];
        end
      end
      if (capture_b) begin
        st_nxt.gr[0][1] = st_r.c0;
        if (buffer_en) begin
          st_nxt.gr[0][3] = st_r.gr[0][1];
        end
      end
    end
    // flags: set wins over clear
    if (clr_cmpa) begin
      st_nxt.fcmp = 1'b0;
    end
    if (clr_udf) begin
      st_nxt.fudf = 1'b0;
    end
    if (clr_ovf) begin
      st_nxt.fovf = 1'b0;
    end
    if (top_hit || udf_hit || rs_match || oc_match_a) begin
      st_nxt.fcmp = 1'b1; // set at each turn
    end
    if (udf_hit) begin
      st_nxt.fudf = 1'b1;
    end
    if (wrap0 && (!comp_mode || ovf_allow)) begin
      st_nxt.fovf = 1'b1;
    end
  end
  // state register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  // output pairs, pwm pins only live in complementary mode
  cpwm_pair u_pair1 (
    .clk         (clk),
    .rst_n       (rst_n),
    .comp_mode   (comp_mode),
    .cnt0        (st_r.c0),
    .cnt1        (st_r.c1),
    .duty        (st_r.gr[0][1]),
    .cycle       (st_r.gr[0][0]),
    .normal_out  (pwm1_normal_out),
    .inverse_out (pwm1_inverse_out)
  );
  cpwm_pair u_pair2 (
    .clk         (clk),
    .rst_n       (rst_n),
    .comp_mode   (comp_mode),
    .cnt0        (st_r.c0),
    .cnt1        (st_r.c1),
    .duty        (st_r.gr[1][0]),
    .cycle       (st_r.gr[0][0]),
    .normal_out  (pwm2_normal_out),
    .inverse_out (pwm2_inverse_out)
  );
  cpwm_pair u_pair3 (
    .clk         (clk),
    .rst_n       (rst_n),
    .comp_mode   (comp_mode),
    .cnt0        (st_r.c0),
    .cnt1        (st_r.c1),
    .duty        (st_r.gr[1][1]),
    .cycle       (st_r.gr[0][0]),
    .normal_out  (pwm3_normal_out),
    .inverse_out (pwm3_inverse_out)
  );
  // readback
  assign counter_ch0          = st_r.c0;
  assign counter_ch1          = st_r.c1;
  assign cycle_compare_ch0    = st_r.gr[0][0];
  assign duty_compare_pair1   = st_r.gr[0][1];
  assign duty_compare_pair2   = st_r.gr[1][0];
  assign duty_compare_pair3   = st_r.gr[1][1];
  assign general_reg_c0       = st_r.gr[0][2];
  assign general_reg_d0       = st_r.gr[0][3];
  assign general_reg_c1       = st_r.gr[1][2];
  assign general_reg_d1       = st_r.gr[1][3];
  assign counting_down        = st_r.down;
  assign compare_a_match_flag = st_r.fcmp;
  assign underflow_flag       = st_r.fudf;
  assign overflow_flag        = st_r.fovf;
  assign cycle_toggle_out     = st_r.tog;
  // turn sequences
  sequence s_top;
    top_hit && !cnt0_wr && !cnt1_wr;
  endsequence
  sequence s_udf;
    udf_hit && !cnt0_wr && !cnt1_wr;
  endsequence
  chk_top_turn_down: assert property (@(posedge clk) disable iff (!rst_n)
    s_top |=> counting_down)
    else $error("no down turn at cycle match");
  chk_udf_turn_up: assert property (@(posedge clk) disable iff (!rst_n)
    s_udf |=> !counting_down)
    else $error("no up turn at underflow");
  chk_turn_flag: assert property (@(posedge clk) disable iff (!rst_n)
    (top_hit || udf_hit) |=> compare_a_match_flag)
    else $error("compare flag not set at turn");
  chk_udf_flag: assert property (@(posedge clk) disable iff (!rst_n)
    udf_hit |=> underflow_flag)
    else $error("underflow flag not set");
  chk_ovf_block: assert property (@(posedge clk) disable iff (!rst_n)
    (comp_mode && !ovf_allow && !overflow_flag) |=>
      !$rose(overflow_flag))
    else $error("overflow flagged on fast clock");
  chk_toggle_turn: assert property (@(posedge clk) disable iff (!rst_n)
    (comp_mode && $changed(cycle_toggle_out)) |-> $past(top_hit))
    else $error("toggle outside cycle turn");
  chk_buf_turn: assert property (@(posedge clk) disable iff (!rst_n)
    (buffer_en && (top_hit || udf_hit) && !capture_b && gr0_wr == 4'h0)
      |=> duty_compare_pair1 == $past(general_reg_d0))
    else $error("buffer not moved at turn");
  chk_cap_buffer: assert property (@(posedge clk) disable iff (!rst_n)
    (!comp_mode && mode == 2'b11 && buffer_en && capture_a)
      |=> general_reg_c0 == $past(cycle_compare_ch0))
    else $error("capture did not shift old value");
  chk_step_lock: assert property (@(posedge clk) disable iff (!rst_n)
    (comp_mode && tick && !cnt0_wr && !cnt1_wr) |=>
      (counter_ch0 - counter_ch1) == $past(counter_ch0 - counter_ch1))
    else $error("counters lost their gap");
endmodule

// ==== core/cpwm_pkg.sv ====
// shared constants and types for the complementary pwm timer
package cpwm_pkg;
  localparam int          CNT_W      = 16;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [2:0]  PSC_DIV1   = 3'h0;
  localparam logic [2:0]  PSC_DIV2   = 3'h1;
  localparam logic [2:0]  PSC_DIV4   = 3'h2;
  localparam logic [2:0]  PSC_DIV8   = 3'h3;
  localparam logic [2:0]  DIV_MASK2  = 3'h1;
  localparam logic [2:0]  DIV_MASK4  = 3'h3;
  localparam logic [2:0]  DIV_MASK8  = 3'h7;
  // operating modes of the two linked channels
  typedef enum logic [1:0] {
    CPWM_MODE_IDLE = 2'b00,
    CPWM_MODE_COMP = 2'b01,
    CPWM_MODE_RSYN = 2'b10,
    CPWM_MODE_OCIC = 2'b11
  } cpwm_mode_t;
endpackage

// ==== core/cpwm_prescale.sv ====
// prescaler producing the count enable pulse
`timescale 1ns/1ps
module cpwm_prescale (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       run,
  input  wire logic [2:0] sel,
  // enable pulse
  output logic            tick
);
  typedef struct packed {
    logic [2:0] div;   // free divider count
  } cpwm_ps_state_t;
  cpwm_ps_state_t st_r;
  cpwm_ps_state_t st_nxt;
  logic [2:0]     mask;
  // mask of divider bits that must be all ones for a tick
  always_comb begin
    case (sel)
      cpwm_pkg::PSC_DIV2: mask = cpwm_pkg::DIV_MASK2;
      cpwm_pkg::PSC_DIV4: mask = cpwm_pkg::DIV_MASK4;
      cpwm_pkg::PSC_DIV8: mask = cpwm_pkg::DIV_MASK8;
      default:            mask = 3'h0;
    endcase
    st_nxt = st_r;
    st_nxt.div = run ? 3'(st_r.div + 3'h1) : 3'h0;
  end
  assign tick = run && ((st_r.div & mask) == mask);
  // divider register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ==== core/cpwm_pair.sv ====
// one normal/counter-phase output pair of the complementary pwm
`timescale 1ns/1ps
module cpwm_pair (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // counters and duty
  input  wire logic        comp_mode,
  input  wire logic [15:0] cnt0,
  input  wire logic [15:0] cnt1,
  input  wire logic [15:0] duty,
  input  wire logic [15:0] cycle,
  // outputs
  output logic             normal_out,
  output logic             inverse_out
);
  typedef struct packed {
    logic nrm;   // normal phase level
    logic inv;   // counter phase level
  } cpwm_pr_state_t;
  cpwm_pr_state_t st_r;
  cpwm_pr_state_t st_nxt;
  // normal phase high while counter 1 is at or over duty; counter phase
  // high while counter 0 and counter 1 are both below duty; the gap between counters keeps
  // both low in between so they never overlap
  always_comb begin
    st_nxt = st_r;
    if (!comp_mode) begin
      st_nxt.nrm = 1'b0;
      st_nxt.inv = 1'b0;
    end else if (duty == cpwm_pkg::CNT_ZERO) begin
      st_nxt.nrm = 1'b1; // full duty
      st_nxt.inv = 1'b0;
    end else if (duty >= cycle) begin
      st_nxt.nrm = 1'b0; // zero duty
      st_nxt.inv = 1'b1;
    end else begin
      st_nxt.nrm = (cnt1 >= duty); // unsigned compare
      st_nxt.inv = (cnt0 < duty) && !(cnt1 >= duty);
    end
  end
  assign normal_out  = st_r.nrm;
  assign inverse_out = st_r.inv;
  // output flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  chk_no_overlap: assert property (@(posedge clk) disable iff (!rst_n)
    !(normal_out && inverse_out))
    else $error("pair outputs overlap");
endmodule

// ==== verif/cpwm_gate_model.sv ====
// gate driver model watching the three output legs
`timescale 1ns/1ps
module cpwm_gate_model (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // gate drive pins of the three legs
  input  wire logic [2:0] hi_side,
  input  wire logic [2:0] lo_side,
  // event counts
  output int              shoot_cnt,
  output int              edge_cnt
);
  logic [2:0] hi_q;  // last high-side levels
  // both switches of one leg on together would short the supply
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shoot_cnt <= 0;
      edge_cnt  <= 0;
      hi_q      <= 3'h0;
    end else begin
      hi_q <= hi_side;
      // count overlap of normal and counter phase
      if ((hi_side & lo_side) != 3'h0) shoot_cnt <= shoot_cnt + 1;
      // count switching of the high side
      if (hi_side != hi_q) edge_cnt <= edge_cnt + 1;
    end
  end
endmodule

// ==== verif/cpwm_timer_tb_top.sv ====
// self-checking bench for the complementary pwm timer
`timescale 1ns/1ps
module cpwm_timer_tb_top;
  localparam logic [15:0] CY  = 16'h0028;  // cycle register value
  localparam logic [15:0] GAP = 16'h0004;  // non-overlap gap
  // stimulus
  logic              clk, rst_n, run, ben, c0w, c1w;
  logic [1:0]        mode;
  logic [2:0]        psel;
  logic [4:0]        stb;     // ovf, udf, cmpa clears, capture b, a
  logic [3:0]        g0w, g1w;
  logic [15:0]       cd, gd;
  // design outputs
  logic [15:0]       q0, q1, qa0, qp1, qp2, qp3, qc0, qd0, qc1, qd1;
  logic              qdn, qfa, qfu, qfo, qtg;
  logic [2:0]        qn, qi;
  int                bad_count, cmp_count, shoot, edges;
  logic [31:0]       rs;
  // reference model state
  logic [15:0]       m0, m1, mcy, st;
  logic [2:0][15:0]  md, mb;
  logic [2:0]        en, ei;
  logic              mdn, mtg, mfa, mfu, mv, xf, tt, tb;
  wire               mon = mode == 2'h1 && run && psel == 3'h0;

  cpwm_timer cpwm_timer_i (
    .clk(clk), .rst_n(rst_n), .mode(mode), .run(run), .buffer_en(ben),
    .prescale_sel_bit2(psel[2]), .prescale_sel_bit1(psel[1]),
    .prescale_sel_bit0(psel[0]), .cnt0_wr(c0w), .cnt1_wr(c1w),
    .cnt_wdata(cd), .gr0_wr(g0w), .gr1_wr(g1w), .gr_wdata(gd),
    .capture_a(stb[0]), .capture_b(stb[1]), .clr_cmpa(stb[2]),
    .clr_udf(stb[3]), .clr_ovf(stb[4]), .counter_ch0(q0),
    .counter_ch1(q1), .cycle_compare_ch0(qa0), .duty_compare_pair1(qp1),
    .duty_compare_pair2(qp2), .duty_compare_pair3(qp3),
    .general_reg_c0(qc0), .general_reg_d0(qd0), .general_reg_c1(qc1),
    .general_reg_d1(qd1), .counting_down(qdn),
    .compare_a_match_flag(qfa), .underflow_flag(qfu),
    .overflow_flag(qfo), .pwm1_normal_out(qn[0]),
    .pwm1_inverse_out(qi[0]), .cycle_toggle_out(qtg),
    .pwm2_normal_out(qn[1]), .pwm2_inverse_out(qi[1]),
    .pwm3_normal_out(qn[2]), .pwm3_inverse_out(qi[2])
  );

  cpwm_gate_model cpwm_gate_model_i (
    .clk(clk), .rst_n(rst_n), .hi_side(qn), .lo_side(qi),
    .shoot_cnt(shoot), .edge_cnt(edges)
  );

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // compares a seen value with the expected one
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // prints the counts and the verdict
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // xorshift step for random values
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  // duty pick: full, zero or a legal switching point
  function automatic logic [15:0] duty(input logic [31:0] r);
    case (r[5:4])
      2'h0:    return 16'h0000;
      2'h1:    return CY;
      default: return GAP + {11'h000, r[12:8]};
    endcase
  endfunction

  // one general register write strobe
  task automatic wr(input int ch, input int b, input logic [15:0] d);
    @(posedge clk);
    gd <= d;
    if (ch == 0) g0w <= 4'h1 << b;
    else g1w <= 4'h1 << b;
    @(posedge clk);
    g0w <= 4'h0;
    g1w <= 4'h0;
  endtask

  // write duty register of pair i, or its buffer
  task automatic wp(input int i, input int bf, input logic [15:0] d);
    wr(i == 0 ? 0 : 1, (i == 1 ? 0 : 1) + (bf != 0 ? 2 : 0), d);
  endtask

  // counter load strobe
  task automatic cw(input logic one, input logic [15:0] d);
    @(posedge clk);
    cd  <= d;
    c0w <= !one;
    c1w <= one;
    @(posedge clk);
    c0w <= 1'b0;
    c1w <= 1'b0;
  endtask

  // one-cycle pulse on capture and clear strobes
  task automatic pulse(input logic [4:0] s);
    @(posedge clk);
    stb <= s;
    @(posedge clk);
    stb <= 5'h00;
  endtask

  // reference model: up/down counting, turns, flags, buffer moves
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {m0, m1, mcy, md, mb, mdn, mtg, mfa, mfu, mv, en, ei} = '0;
    end else begin
      mv = mon;
      // duty zero gives full on, duty at or over cycle gives full off
      for (int i = 0; i < 3; i++) begin
        en[i] = md[i] == 16'h0000 || (md[i] < mcy && m1 >= md[i]);
        ei[i] = md[i] != 16'h0000 && !en[i] && (md[i] >= mcy || m0 < md[i]);
      end
      xf = 1'b0;
      if (stb[2]) mfa = 1'b0;
      if (stb[3]) mfu = 1'b0;
      if (mon) begin
        tt = !mdn && m0 == mcy;
        tb = mdn && m1 == 16'h0000;
        st = mdn ? 16'hFFFF : 16'h0001;
        m0 = m0 + st;
        m1 = m1 + st;
        if (tt || tb) begin
          mdn = tt;
          mfa = 1'b1;
          xf  = ben;
        end
        if (tt) mtg = !mtg;
        if (tb) mfu = 1'b1;
      end
      if (xf) md = mb;
      if (c0w) m0 = cd;
      if (c1w) m1 = cd;
      if (g0w[0]) mcy = gd;
      if (g0w[1] && !xf) md[0] = gd;
      if (g0w[3]) mb[0] = gd;
      if (g1w[0] && !xf) md[1] = gd;
      if (g1w[2]) mb[1] = gd;
      if (g1w[1] && !xf) md[2] = gd;
      if (g1w[3]) mb[2] = gd;
    end
  end

  // design against model between edges while complementary runs on the undivided clock
  always @(negedge clk) begin
    if (mv) begin
      chk(q0, m0);
      chk(q1, m1);
      chk(16'(qdn), 16'(mdn));
      chk(16'({qfa, qfu, qfo}), 16'({mfa, mfu, 1'b0}));
      chk(qp1, md[0]);
      chk(qp2, md[1]);
      chk(qp3, md[2]);
      chk(16'(qtg), 16'(mtg));
      chk(16'({qn, qi}), 16'({en, ei}));
    end
  end

  // watchdog against a hang
  initial begin
    #100000;
    bad_count++;
    test_done();
  end

  // main sequence
  initial begin
    {rst_n, run, ben, c0w, c1w, mode, psel, stb, g0w, g1w} = '0;
    {cd, gd, bad_count, cmp_count} = '0;
    rs = 32'h0000_80E2;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    mode  <= 2'h1;
    ben   <= 1'b1;
    wr(0, 0, CY);
    wr(0, 2, CY);
    for (int i = 0; i < 3; i++) begin
      wp(i, 0, 16'h000A + 16'(8 * i));
      wp(i, 1, 16'h000A + 16'(8 * i));
    end
    cw(1'b0, GAP);
    cw(1'b1, 16'h0000);
    @(posedge clk);
    run <= 1'b1;
    repeat (12) begin
      repeat (30) @(posedge clk);
      rs = xs(rs);
      wp(rs % 3, 1, duty(rs));
    end
    pulse(5'h0C);
    repeat (3) @(posedge clk);
    run <= 1'b0;
    pulse(5'h10);
    psel <= 3'h2;
    run  <= 1'b1;
    repeat (1000) @(posedge clk);
    @(negedge clk);
    chk(16'({qfo, qfu}), 16'h0003);
    @(posedge clk);
    psel <= 3'h1;
    pulse(5'h10);
    repeat (400) @(posedge clk);
    @(negedge clk);
    chk(16'(qfo), 16'h0000);
    @(posedge clk);
    run  <= 1'b0;
    mode <= 2'h3;
    psel <= 3'h0;
    cw(1'b0, 16'h1234);
    wr(0, 0, 16'h00AA);
    pulse(5'h01);
    @(negedge clk);
    chk(qa0, 16'h1234);
    chk(qc0, 16'h00AA);
    cw(1'b0, 16'h4321);
    wr(0, 1, 16'h0055);
    pulse(5'h02);
    @(negedge clk);
    chk(qp1, 16'h4321);
    chk(qd0, 16'h0055);
    cw(1'b0, 16'h0000);
    wr(0, 0, 16'h000A);
    wr(0, 2, 16'h0037);
    @(posedge clk);
    run <= 1'b1;
    for (int i = 0; i < 40 && qa0 !== 16'h0037; i++) @(negedge clk);
    chk(qa0, 16'h0037);
    @(posedge clk);
    run  <= 1'b0;
    mode <= 2'h2;
    cw(1'b0, 16'h0000);
    wr(0, 0, 16'h0014);
    wr(0, 2, 16'h0014);
    wr(0, 1, 16'h0005);
    wr(0, 3, 16'h0009);
    @(posedge clk);
    run <= 1'b1;
    for (int i = 0; i < 60 && qp1 !== 16'h0009; i++) @(negedge clk);
    chk(qp1, 16'h0009);
    chk(16'(shoot), 16'h0000);
    chk(16'(edges > 0), 16'h0001);
    test_done();
  end
endmodule
